// ==== include/mrlr_pkg.sv ====
// Package for the monitor result and limit register bank.
// Assumes one 10 MHz clock and a register port driven by the serial slave.
package mrlr_pkg;

  // Register pointer values seen on the register port
  localparam logic [7:0] ADDR_CH1_SHUNT = 8'h01;
  localparam logic [7:0] ADDR_CH1_BUS = 8'h02;
  localparam logic [7:0] ADDR_CH2_SHUNT = 8'h03;
  localparam logic [7:0] ADDR_CH2_BUS = 8'h04;
  localparam logic [7:0] ADDR_CH3_SHUNT = 8'h05;
  localparam logic [7:0] ADDR_CH3_BUS = 8'h06;
  localparam logic [7:0] ADDR_FAST_LIMIT = 8'h07;
  localparam logic [7:0] ADDR_SLOW_LIMIT = 8'h08;

  // Values after reset and for unmapped reads
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] LIMIT_RESET = 16'h7FF8;
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;

  // Field positions: sign, magnitude and the signed 13-bit value
  localparam int SIGN_BIT = 15;
  localparam int MAG_HI = 14;
  localparam int MAG_LO = 3;
  localparam int VAL_W = 13;

  // Channel codes and sizes
  localparam int NUM_CH = 3;
  localparam logic [1:0] CH1 = 2'h0;
  localparam int AVG_SEL_W = 3;
  localparam int CNT_W = 11;
  localparam int SUM_W = 23;
  localparam logic [2:0] LOW_PAD = 3'h0;

  // One conversion from the conversion engine
  typedef struct packed {
    logic valid;
    logic [1:0] channel;
    logic isBus;
    logic [15:0] data;
  } mrlr_conv_t;

  // One finished average of shunt samples
  typedef struct packed {
    logic valid;
    logic [1:0] channel;
    logic [15:0] data;
  } mrlr_avg_t;

  // One register access from the serial slave
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [15:0] wrData;
  } mrlr_reg_req_t;

endpackage : mrlr_pkg

// ==== src/mrlr_shunt_averager.sv ====
// Per-channel shunt averager for the monitor register bank.
// Assumes conversions arrive as one-cycle pulses, one channel at a time.
`timescale 1ns/1ns
module mrlr_shunt_averager (
  input wire logic sys_clk,
  input wire logic rstn,
  input mrlr_pkg::mrlr_conv_t conv,
  input wire logic [mrlr_pkg::AVG_SEL_W-1:0] sampleAverageCount,
  output mrlr_pkg::mrlr_avg_t avgOut
);
  import mrlr_pkg::*;

  // Sample count for each averaging code
  function automatic logic [CNT_W-1:0] avgTarget(input logic [AVG_SEL_W-1:0] sel);
    case (sel)
      3'h0: avgTarget = 11'h001;
      3'h1: avgTarget = 11'h004;
      3'h2: avgTarget = 11'h010;
      3'h3: avgTarget = 11'h040;
      3'h4: avgTarget = 11'h080;
      3'h5: avgTarget = 11'h100;
      3'h6: avgTarget = 11'h200;
      default: avgTarget = 11'h400;
    endcase
  endfunction : avgTarget

  // Division by the count is a shift because every count is a power of two
  function automatic logic [3:0] avgShift(input logic [AVG_SEL_W-1:0] sel);
    case (sel)
      3'h0: avgShift = 4'h0;
      3'h1: avgShift = 4'h2;
      3'h2: avgShift = 4'h4;
      3'h3: avgShift = 4'h6;
      3'h4: avgShift = 4'h7;
      3'h5: avgShift = 4'h8;
      3'h6: avgShift = 4'h9;
      default: avgShift = 4'hA;
    endcase
  endfunction : avgShift

  logic signed [SUM_W-1:0] accR [NUM_CH];
  logic [CNT_W-1:0] cntR [NUM_CH];
  logic [NUM_CH-1:0] hitVec;
  logic [NUM_CH-1:0] doneVec;
  logic [VAL_W-1:0] avgVal [NUM_CH];
  wire logic signed [SUM_W-1:0] sample = SUM_W'(signed'(conv.data[SIGN_BIT:MAG_LO]));
  wire logic [CNT_W-1:0] target = avgTarget(sampleAverageCount);
  wire logic [3:0] shift = avgShift(sampleAverageCount);

  // One accumulator per channel; the run ends when the selected count is met
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    wire logic signed [SUM_W-1:0] total = accR[ch] + sample;
    wire logic signed [SUM_W-1:0] scaled = total >>> shift;
    wire logic [CNT_W-1:0] cntInc = cntR[ch] + 11'h001;
    assign hitVec[ch] = conv.valid && !conv.isBus && (conv.channel == 2'(ch));
    // A shrunk count mid-run still ends the run at that channel's next sample
    assign doneVec[ch] = cntInc >= target;
    assign avgVal[ch] = scaled[VAL_W-1:0];

    always_ff @(posedge sys_clk) begin
      if (!rstn || (hitVec[ch] && doneVec[ch])) begin
        accR[ch] <= '0;
        cntR[ch] <= '0;
      end else if (hitVec[ch]) begin
        accR[ch] <= total;
        cntR[ch] <= cntInc;
      end
    end
  end

  // Publish the finished average, left aligned with zero low bits
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      avgOut <= '0;
    end else begin
      avgOut.valid <= |(hitVec & doneVec);
      avgOut.channel <= conv.channel;
      if (conv.channel < 2'(NUM_CH)) begin
        avgOut.data <= {avgVal[conv.channel], LOW_PAD};
      end
    end
  end

endmodule : mrlr_shunt_averager

// ==== src/mrlr_result_limit_regs.sv ====
// Result and channel-1 limit registers of the three-channel shunt/bus monitor.
// Assumes a serial slave drives the register port and a conversion engine
// delivers signed, left-aligned 13-bit conversions as one-cycle pulses.
// Notes on behaviour
// R1 - Each channel has a read-only averaged shunt result; ch2 at 03h, ch3 at 05h.
// R2 - Shunt magnitude sits in bits 14-3, 40 uV a step, 7FF8 is 163.8 mV.
// R3 - Each channel has a read-only latest bus result; ch2 at 04h, ch3 at 06h.
// R4 - Bus magnitude sits in bits 14-3, 8 mV a step, 7FF8 is 32.76 V.
// R5 - Bit 15 of every result is the sign; negatives in twos complement.
// R6 - Shunt and bus results clear to zero on reset.
// R7 - Channel-1 fast limit at 07h is checked against every single ch1 shunt conversion.
// R8 - Channel-1 slow limit at 08h is checked against the averaged ch1 shunt value.
// R9 - Limits hold a writable value in bits 15-3 and reset to 7FF8h.
// R10 - The averaged shunt updates only after the selected number of samples.
// R11 - Host writes to result registers are ignored; contents stay unchanged.
`timescale 1ns/1ns
module mrlr_result_limit_regs (
  input wire logic sys_clk,
  input wire logic rstn,
  input mrlr_pkg::mrlr_reg_req_t regReq,
  output mrlr_pkg::mrlr_avg_t regRdOut,
  input mrlr_pkg::mrlr_conv_t conv,
  input wire logic [mrlr_pkg::AVG_SEL_W-1:0] sampleAverageCount,
  output logic fastTrip,
  output logic slowTrip,
  output logic fastTripEvent,
  output logic slowTripEvent
);
  import mrlr_pkg::*;

  // Pointer decode used by both the read mux and the write path
  function automatic logic isResultAddr(input logic [7:0] addr);
    isResultAddr = (addr >= ADDR_CH1_SHUNT) && (addr <= ADDR_CH3_BUS);
  endfunction : isResultAddr

  // Result index: two registers per channel, shunt first then bus
  function automatic logic [2:0] resultIndex(input logic [7:0] addr);
    resultIndex = 3'(addr - ADDR_CH1_SHUNT);
  endfunction : resultIndex

  localparam int NUM_RES = 2 * NUM_CH;

  logic [15:0] resultR [NUM_RES];
  logic [15:0] fastLimitR;
  logic [15:0] slowLimitR;
  logic fastTripR;
  logic slowTripR;
  logic fastTripEventR;
  logic slowTripEventR;
  mrlr_avg_t rdOutR;
  mrlr_avg_t avgOut;

  // Averaging of shunt samples per channel
  mrlr_shunt_averager u_averager (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .conv(conv),
    .sampleAverageCount(sampleAverageCount),
    .avgOut(avgOut)
  );

  // Write decode; result pointers are simply not writable
  wire logic wrFast = regReq.wrEn && (regReq.addr == ADDR_FAST_LIMIT);
  wire logic wrSlow = regReq.wrEn && (regReq.addr == ADDR_SLOW_LIMIT);
  wire logic wrResult = regReq.wrEn && isResultAddr(regReq.addr); // see R11
  wire logic rdTake = regReq.rdEn && !wrResult; // see R11

  // Conversion classification
  wire logic convBus = conv.valid && conv.isBus && (conv.channel < 2'(NUM_CH));
  wire logic convCh1Shunt = conv.valid && !conv.isBus && (conv.channel == CH1);
  wire logic avgCh1 = avgOut.valid && (avgOut.channel == CH1);
  wire logic avgAny = avgOut.valid && (avgOut.channel < 2'(NUM_CH));

  // Each stored result keeps the sign in bit 15 and magnitude in 14-3, low bits zero
  wire logic [15:0] busWord = {conv.data[SIGN_BIT:MAG_LO], LOW_PAD}; // see R4
  wire logic [15:0] avgWord = {avgOut.data[SIGN_BIT:MAG_LO], LOW_PAD}; // see R2

  // Signed comparisons on the 13-bit values in bits 15-3
  wire logic signed [VAL_W-1:0] convVal = signed'(conv.data[SIGN_BIT:MAG_LO]); // see R5
  wire logic signed [VAL_W-1:0] avgVal = signed'(avgOut.data[SIGN_BIT:MAG_LO]);
  wire logic signed [VAL_W-1:0] fastVal = signed'(fastLimitR[SIGN_BIT:MAG_LO]);
  wire logic signed [VAL_W-1:0] slowVal = signed'(slowLimitR[SIGN_BIT:MAG_LO]);
  wire logic fastOver = convVal > fastVal; // see R7
  wire logic slowOver = avgVal > slowVal; // see R8

  // Read mux
  wire logic [2:0] rdIdx = resultIndex(regReq.addr);
  wire logic [15:0] rdWord =
    isResultAddr(regReq.addr) ? resultR[rdIdx] :
    (regReq.addr == ADDR_FAST_LIMIT) ? fastLimitR :
    (regReq.addr == ADDR_SLOW_LIMIT) ? slowLimitR : UNMAPPED_READ;

  // Result registers: bus words take the latest reading, shunt words
  // take only finished averages so a partial run is never visible
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_res
    always_ff @(posedge sys_clk) begin
      if (!rstn) begin
        resultR[2*ch] <= RESULT_RESET; // see R6
        resultR[2*ch+1] <= RESULT_RESET; // see R6
      end else begin
        if (avgAny && (avgOut.channel == 2'(ch))) begin
          resultR[2*ch] <= avgWord; // see R1, R10
        end
        if (convBus && (conv.channel == 2'(ch))) begin
          resultR[2*ch+1] <= busWord; // see R3
        end
      end
    end
  end

  // Limit registers; reserved low bits are kept as written
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      fastLimitR <= LIMIT_RESET; // see R9
      slowLimitR <= LIMIT_RESET; // see R9
    end else begin
      if (wrFast) begin
        fastLimitR <= regReq.wrData; // see R9
      end
      if (wrSlow) begin
        slowLimitR <= regReq.wrData; // see R9
      end
    end
  end

  // Fast trip follows every single ch1 shunt conversion, so a short spike
  // is seen even when averaging would smooth it away
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      fastTripR <= 1'b0;
      fastTripEventR <= 1'b0;
    end else begin
      fastTripEventR <= convCh1Shunt && fastOver; // see R7
      if (convCh1Shunt) begin
        fastTripR <= fastOver; // see R7
      end
    end
  end

  // Slow trip follows only finished ch1 averages
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      slowTripR <= 1'b0;
      slowTripEventR <= 1'b0;
    end else begin
      slowTripEventR <= avgCh1 && slowOver; // see R8, R10
      if (avgCh1) begin
        slowTripR <= slowOver; // see R8
      end
    end
  end

  // Read data is registered; a write to a result address gives no read
  // and changes nothing, which keeps the host from corrupting readings
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rdOutR <= '0;
    end else begin
      rdOutR.valid <= rdTake; // see R11
      rdOutR.channel <= 2'h0;
      // A refused read leaves the held data alone as well
      if (rdTake) begin
        rdOutR.data <= rdWord;
      end
    end
  end

  assign regRdOut = rdOutR;
  assign fastTrip = fastTripR;
  assign slowTrip = slowTripR;
  assign fastTripEvent = fastTripEventR;
  assign slowTripEvent = slowTripEventR;

endmodule : mrlr_result_limit_regs

// ==== sim/mrlr_conv_model.sv ====
// Conversion engine stand-in for the register bank bench.
// Assumes callers run on the falling edge of sys_clk.
`timescale 1ns/1ns
module mrlr_conv_model
  import mrlr_pkg::*;
(
  input wire logic sys_clk,
  output mrlr_pkg::mrlr_conv_t conv
);
  initial conv = '0;
  // One-cycle pulse; data flips after it so a stale sample never matches
  task automatic send(input logic [1:0] ch, input logic bus, input logic [15:0] d);
    @(negedge sys_clk);
    conv <= '{valid: 1'b1, channel: ch, isBus: bus, data: d};
    @(negedge sys_clk);
    conv <= '{valid: 1'b0, channel: ch, isBus: bus, data: ~d};
  endtask : send
endmodule : mrlr_conv_model

// ==== sim/mrlr_regs_asserts.sv ====
// Checker for the result and limit register bank.
// Assumes it is bound to mrlr_result_limit_regs.
`timescale 1ns/1ns
module mrlr_regs_asserts
  import mrlr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input mrlr_pkg::mrlr_reg_req_t regReq,
  input mrlr_pkg::mrlr_avg_t regRdOut,
  input mrlr_pkg::mrlr_conv_t conv,
  input wire logic [mrlr_pkg::AVG_SEL_W-1:0] sampleAverageCount,
  input wire logic fastTrip,
  input wire logic slowTrip,
  input wire logic fastTripEvent,
  input wire logic slowTripEvent
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic [15:0] fastLim_r;
  wire logic ch1Shunt = conv.valid && conv.channel == CH1 && !conv.isBus;
  wire logic signed [12:0] convVal = conv.data[15:3];
  wire logic signed [12:0] limVal = fastLim_r[15:3];
  // Shadow of the fast limit, so each compare is judged exactly
  always_ff @(posedge sys_clk) begin
    if (!rstn)
      fastLim_r <= LIMIT_RESET;
    else if (regReq.wrEn && regReq.addr == ADDR_FAST_LIMIT)
      fastLim_r <= regReq.wrData;
  end
  a_read_answers: assert property (regReq.rdEn && !regReq.wrEn |=> regRdOut.valid)
    else $error("read not answered");
  a_valid_cause: assert property (regRdOut.valid |-> $past(regReq.rdEn))
    else $error("read data without request");
  a_reset_clear: assert property ($rose(rstn) |-> !fastTrip && !slowTrip)
    else $error("trip set after reset");
  a_fast_compare: assert property (ch1Shunt |=> fastTrip == ($past(convVal) > $past(limVal)))
    else $error("fast compare wrong");
  a_fast_hold: assert property (!ch1Shunt |=> $stable(fastTrip))
    else $error("fast trip moved without conversion");
  a_fast_event: assert property (fastTripEvent |-> fastTrip && $past(ch1Shunt))
    else $error("fast event without cause");
  a_slow_event: assert property (slowTripEvent |-> slowTrip)
    else $error("slow event without trip");
  a_rd_hold: assert property (!regRdOut.valid && $past(rstn) |-> $stable(regRdOut.data))
    else $error("read data moved without read");
  cover property (fastTripEvent);
  cover property (slowTripEvent);
  cover property (regRdOut.valid && regRdOut.data[15]);
endmodule : mrlr_regs_asserts
bind mrlr_result_limit_regs mrlr_regs_asserts chk (.sys_clk(sys_clk), .rstn(rstn),
  .regReq(regReq), .regRdOut(regRdOut), .conv(conv),
  .sampleAverageCount(sampleAverageCount), .fastTrip(fastTrip), .slowTrip(slowTrip),
  .fastTripEvent(fastTripEvent), .slowTripEvent(slowTripEvent));

// ==== sim/tb_mrlr_result_limit_regs.sv ====
// Self-checking bench for the result and limit register bank.
// Assumes reads answer one cycle after the request.
`timescale 1ns/1ns
module tb_mrlr_result_limit_regs;
  import mrlr_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] avgSel = 3'h0;
  mrlr_reg_req_t req = '0;
  mrlr_conv_t conv;
  mrlr_avg_t rdOut;
  logic fastTrip, slowTrip, fastEv, slowEv;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  logic [15:0] v;
  logic [15:0] s [4];
  logic [15:0] prev;
  int n;
  int sum;
  always #50 sys_clk = ~sys_clk;
  mrlr_conv_model model (.sys_clk(sys_clk), .conv(conv));
  mrlr_result_limit_regs dut (.sys_clk(sys_clk), .rstn(rstn), .regReq(req),
    .regRdOut(rdOut), .conv(conv), .sampleAverageCount(avgSel), .fastTrip(fastTrip),
    .slowTrip(slowTrip), .fastTripEvent(fastEv), .slowTripEvent(slowEv));
  task automatic complete_run();
    $display("counts: %0d checks, %0d mismatches", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    req <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
    @(negedge sys_clk);
    req <= '0;
  endtask : wr
  // Valid is looked at in the one cycle it stands
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge sys_clk);
    req <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 16'h0000};
    @(negedge sys_clk);
    req <= '0;
    chk({13'h0000, rdOut.channel, rdOut.valid}, 16'h0001);
    chk(rdOut.data, exp);
  endtask : rd
  // One ch1 shunt sample against both limits, each set to 0100h (value 20h)
  task automatic trip_case(input logic [15:0] d);
    logic trip;
    trip = $signed(d[15:3]) > 13'sh0020;
    model.send(CH1, 1'b0, d);
    chk({13'h0000, fastTrip, fastEv, slowEv}, {13'h0000, trip, trip, 1'b0});
    @(negedge sys_clk);
    chk({13'h0000, slowTrip, slowEv, fastEv}, {13'h0000, trip, trip, 1'b0});
  endtask : trip_case
  // Samples per averaging code: 1, 4, 16, 64, 128, 256, 512, 1024
  function automatic int samples_for(input int code);
    return (code < 4) ? (1 << (2 * code)) : (1 << (code + 3));
  endfunction : samples_for
  // Floor of the mean of four signed 13-bit samples, left-aligned
  function automatic logic [15:0] avg4();
    logic signed [14:0] t;
    t = 15'h0000;
    for (int i = 0; i < 4; i++) t += $signed(s[i][15:3]);
    return {t[14:2], LOW_PAD};
  endfunction : avg4
  // Hang guard: the tests need about 4200 cycles, mostly the long averages
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(32'h1498c6ea));
    repeat (3) @(negedge sys_clk);
    rstn = 1'b1;
    for (int a = 3; a <= 8; a++) rd(8'(a), (a < 7) ? RESULT_RESET : LIMIT_RESET);
    rd(8'h20, UNMAPPED_READ);
    $display("test reset done");
    for (int a = 3; a <= 6; a++) wr(8'(a), 16'($urandom));
    for (int a = 3; a <= 6; a++) rd(8'(a), RESULT_RESET);
    // A read that comes with a result write is refused whole
    @(negedge sys_clk);
    req <= '{wrEn: 1'b1, rdEn: 1'b1, addr: ADDR_CH2_BUS, wrData: 16'hFFF8};
    @(negedge sys_clk);
    req <= '0;
    chk({15'h0000, rdOut.valid}, 16'h0000);
    rd(ADDR_CH2_BUS, RESULT_RESET);
    v = 16'($urandom);
    wr(ADDR_FAST_LIMIT, v);
    wr(ADDR_SLOW_LIMIT, 16'h8000);
    rd(ADDR_FAST_LIMIT, v);
    rd(ADDR_SLOW_LIMIT, 16'h8000);
    $display("test access done");
    s = '{16'h7FF8, 16'h8000, 16'h0008, 16'($urandom)};
    foreach (s[i]) begin
      model.send(2'h1, 1'b1, s[i]);
      model.send(2'h2, 1'b1, ~s[i]);
      rd(ADDR_CH2_BUS, {s[i][15:3], LOW_PAD});
      rd(ADDR_CH3_BUS, {~s[i][15:3], LOW_PAD});
    end
    $display("test bus done");
    avgSel = 3'h1;
    foreach (s[i]) s[i] = 16'($urandom);
    s[0] = 16'h8000;
    for (int i = 0; i < 3; i++) model.send(2'h1, 1'b0, s[i]);
    rd(ADDR_CH2_SHUNT, RESULT_RESET);
    model.send(2'h1, 1'b0, s[3]);
    rd(ADDR_CH2_SHUNT, avg4());
    $display("test average done");
    avgSel = 3'h0;
    wr(ADDR_FAST_LIMIT, 16'h0100);
    wr(ADDR_SLOW_LIMIT, 16'h0100);
    s = '{16'h0108, 16'h0100, 16'hFFF8, 16'h7FF8};
    foreach (s[i]) trip_case(s[i]);
    repeat (8) trip_case(16'($urandom));
    $display("test trips done");
    // Every longer averaging code on ch3; the result holds until the last sample
    prev = RESULT_RESET;
    for (int k = 2; k < 8; k++) begin
      avgSel = 3'(k);
      n = samples_for(k);
      sum = 0;
      for (int i = 0; i < n; i++) begin
        v = 16'($urandom);
        sum += $signed(v[15:3]);
        model.send(2'h2, 1'b0, v);
        if (i == n - 2) rd(ADDR_CH3_SHUNT, prev);
      end
      sum = sum >>> $clog2(n);
      prev = {sum[12:0], LOW_PAD};
      rd(ADDR_CH3_SHUNT, prev);
    end
    $display("test codes done");
    // Mid-run reset over set trips, written limits and a partial ch2 run
    avgSel = 3'h0;
    trip_case(16'h7FF8);
    avgSel = 3'h1;
    model.send(2'h1, 1'b0, 16'h7FF8);
    @(negedge sys_clk);
    rstn = 1'b0;
    repeat (3) @(negedge sys_clk);
    rstn = 1'b1;
    chk({14'h0000, fastTrip, slowTrip}, 16'h0000);
    for (int a = 3; a <= 8; a++) rd(8'(a), (a < 7) ? RESULT_RESET : LIMIT_RESET);
    s = '{16'h0008, 16'hFFF8, 16'h7FF8, 16'h8000};
    foreach (s[i]) model.send(2'h1, 1'b0, s[i]);
    rd(ADDR_CH2_SHUNT, avg4());
    $display("test mid reset done");
    complete_run();
  end
endmodule : tb_mrlr_result_limit_regs
